// file: logic/tds_pkg.sv
/*
 holds register offsets, reset values and widths of the descriptor scan maps.
 assumes a 32-bit classic wishbone register port with byte addresses.
*/
`default_nettype none
package tds_pkg;

    // ========================================================
    // geometry
    localparam int NUM_CAT = 3;
    localparam int NUM_DESC = 32;
    localparam int IDX_W = 5;
    localparam int ADR_W = 12;

    // ========================================================
    // categories
    localparam int CAT_ISO = 0;
    localparam int CAT_PERIODIC = 1;
    localparam int CAT_ASYNC = 2;

    // ========================================================
    // register offsets, byte addresses
    localparam logic [ADR_W-1:0] ISO_COMPLETION_OFS = 12'h130;
    localparam logic [ADR_W-1:0] ISO_SKIP_OFS = 12'h134;
    localparam logic [ADR_W-1:0] ISO_SCAN_END_OFS = 12'h138;
    localparam logic [ADR_W-1:0] PERIODIC_COMPLETION_OFS = 12'h140;
    localparam logic [ADR_W-1:0] PERIODIC_SKIP_OFS = 12'h144;
    localparam logic [ADR_W-1:0] PERIODIC_SCAN_END_OFS = 12'h148;
    localparam logic [ADR_W-1:0] ASYNC_COMPLETION_OFS = 12'h150;
    localparam logic [ADR_W-1:0] ASYNC_SKIP_OFS = 12'h154;
    localparam logic [ADR_W-1:0] ASYNC_SCAN_END_OFS = 12'h158;
    localparam logic [ADR_W-1:0] IRQ_STATUS_OFS = 12'h160;
    localparam logic [ADR_W-1:0] IRQ_MASK_OFS = 12'h164;
    localparam logic [ADR_W-1:0] SCAN_CTRL_OFS = 12'h168;

    // ========================================================
    // reset values
    localparam logic [31:0] COMPLETION_RST = 32'h0000_0000;
    localparam logic [31:0] SKIP_RST = 32'hffff_ffff;
    localparam logic [31:0] SCAN_END_RST = 32'h0000_0000;
    localparam logic [2:0] IRQ_STATUS_RST = 3'h0;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    localparam logic [2:0] SCAN_CTRL_RST = 3'h0;

    // ========================================================
    // timing: clock cycles between two scan steps
    localparam int SCAN_STEP_DIV = 4;

endpackage
`default_nettype wire

// file: logic/tds_scan_maps.sv
/*
 skip, scan-end and completion bitmaps for three descriptor categories,
 their scanners, an interrupt status/mask pair and a wishbone slave.
 assumes the transfer engine pulses completion bits on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tds_scan_maps
    import tds_pkg::*;
#(
    parameter int STEP_DIV = SCAN_STEP_DIV
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // completion pulses from the transfer engine
    input wire logic [NUM_DESC-1:0] iso_done_i,
    input wire logic [NUM_DESC-1:0] periodic_done_i,
    input wire logic [NUM_DESC-1:0] async_done_i,
    // iso scanner
    output logic iso_visit_o,
    output logic [IDX_W-1:0] iso_visit_idx_o,
    output logic iso_wrap_o,
    // periodic scanner
    output logic periodic_visit_o,
    output logic [IDX_W-1:0] periodic_visit_idx_o,
    output logic periodic_wrap_o,
    // async scanner
    output logic async_visit_o,
    output logic [IDX_W-1:0] async_visit_idx_o,
    output logic async_wrap_o,
    // interrupt
    output logic irq_o
);

    // ========================================================
    // helpers
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic adr_hit(
        input logic [ADR_W-1:0] adr,
        input logic [ADR_W-1:0] ofs
    );
        return adr[ADR_W-1:2] == ofs[ADR_W-1:2];
    endfunction

    // ========================================================
    // per-category offset tables
    localparam logic [ADR_W-1:0] COMP_OFS [NUM_CAT] =
        '{ISO_COMPLETION_OFS, PERIODIC_COMPLETION_OFS, ASYNC_COMPLETION_OFS};
    localparam logic [ADR_W-1:0] SKIP_OFS [NUM_CAT] =
        '{ISO_SKIP_OFS, PERIODIC_SKIP_OFS, ASYNC_SKIP_OFS};
    localparam logic [ADR_W-1:0] END_OFS [NUM_CAT] =
        '{ISO_SCAN_END_OFS, PERIODIC_SCAN_END_OFS, ASYNC_SCAN_END_OFS};

    // ========================================================
    // bus request decode
    logic req;
    logic wr_req;
    logic rd_req;
    logic hit_status;
    logic hit_mask;
    logic hit_ctrl;
    logic [NUM_CAT-1:0] hit_comp;
    logic [NUM_CAT-1:0] hit_skip;
    logic [NUM_CAT-1:0] hit_end;
    logic [NUM_CAT-1:0] comp_clr;
    logic status_we;
    logic mask_we;
    logic ctrl_we;
    logic [NUM_CAT-1:0] skip_we;
    logic [NUM_CAT-1:0] end_we;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_req = req & wb_we_i;
    assign rd_req = req & ~wb_we_i;
    assign hit_status = adr_hit(wb_adr_i, IRQ_STATUS_OFS);
    assign hit_mask = adr_hit(wb_adr_i, IRQ_MASK_OFS);
    assign hit_ctrl = adr_hit(wb_adr_i, SCAN_CTRL_OFS);
    assign status_we = wr_req & hit_status & wb_sel_i[0];
    assign mask_we = wr_req & hit_mask & wb_sel_i[0];
    assign ctrl_we = wr_req & hit_ctrl & wb_sel_i[0];

    // ========================================================
    // map registers
    logic [NUM_DESC-1:0] comp_r [NUM_CAT];
    logic [NUM_DESC-1:0] comp_nxt [NUM_CAT];
    logic [NUM_DESC-1:0] skip_r [NUM_CAT];
    logic [NUM_DESC-1:0] end_r [NUM_CAT];
    logic [NUM_DESC-1:0] done_in [NUM_CAT];
    logic [NUM_CAT-1:0] cat_event;

    assign done_in[CAT_ISO] = iso_done_i;
    assign done_in[CAT_PERIODIC] = periodic_done_i;
    assign done_in[CAT_ASYNC] = async_done_i;

    for (genvar c = 0; c < NUM_CAT; c++)
    begin : g_cat
        assign hit_comp[c] = adr_hit(wb_adr_i, COMP_OFS[c]);
        assign hit_skip[c] = adr_hit(wb_adr_i, SKIP_OFS[c]);
        assign hit_end[c] = adr_hit(wb_adr_i, END_OFS[c]);
        assign skip_we[c] = wr_req & hit_skip[c];
        assign end_we[c] = wr_req & hit_end[c];
        assign comp_clr[c] = rd_req & hit_comp[c];
        assign comp_nxt[c] = (comp_clr[c] ? '0 : comp_r[c]) | done_in[c];
        assign cat_event[c] = |done_in[c];

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                comp_r[c] <= COMPLETION_RST;
                skip_r[c] <= SKIP_RST;
                end_r[c] <= SCAN_END_RST;
            end
            else
            begin
                comp_r[c] <= comp_nxt[c];
                if (skip_we[c])
                begin
                    skip_r[c] <= lane_merge(skip_r[c], wb_dat_i, wb_sel_i);
                end
                if (end_we[c])
                begin
                    end_r[c] <= lane_merge(end_r[c], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    // ========================================================
    // interrupt status, mask and scan control
    logic [NUM_CAT-1:0] irq_status_r;
    logic [NUM_CAT-1:0] irq_status_nxt;
    logic [NUM_CAT-1:0] irq_mask_r;
    logic [NUM_CAT-1:0] scan_en_r;
    logic [NUM_CAT-1:0] status_w1c;
    logic [NUM_CAT-1:0] irq_mask_nxt;
    logic irq_nxt;

    assign status_w1c = status_we ? wb_dat_i[NUM_CAT-1:0] : '0;
    assign irq_status_nxt = (irq_status_r & ~status_w1c) | cat_event;
    assign irq_mask_nxt = mask_we ? wb_dat_i[NUM_CAT-1:0] : irq_mask_r;
    assign irq_nxt = |(irq_status_nxt & irq_mask_nxt);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_status_r <= IRQ_STATUS_RST;
            irq_mask_r <= IRQ_MASK_RST;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_status_r <= irq_status_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_o <= irq_nxt;
        end
    end

    // ========================================================
    // scan enable control
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scan_en_r <= SCAN_CTRL_RST;
        end
        else if (ctrl_we)
        begin
            scan_en_r <= wb_dat_i[NUM_CAT-1:0];
        end
    end

    // ========================================================
    // read data select
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = '0;
        for (int c = 0; c < NUM_CAT; c++)
        begin
            if (hit_comp[c])
            begin
                rd_mux = comp_r[c];
            end
            if (hit_skip[c])
            begin
                rd_mux = skip_r[c];
            end
            if (hit_end[c])
            begin
                rd_mux = end_r[c];
            end
        end
        if (hit_status)
        begin
            rd_mux = {29'h0, irq_status_r};
        end
        if (hit_mask)
        begin
            rd_mux = {29'h0, irq_mask_r};
        end
        if (hit_ctrl)
        begin
            rd_mux = {29'h0, scan_en_r};
        end
    end

    // ========================================================
    // bus answer: one wait-free ack, unmapped reads give zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= req;
            if (rd_req)
            begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    // ========================================================
    // scan step divider
    localparam int DIV_W = $clog2(STEP_DIV + 1);
    logic [DIV_W-1:0] div_r;
    logic step;

    assign step = (div_r == DIV_W'(STEP_DIV - 1));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_r <= '0;
        end
        else
        begin
            div_r <= step ? '0 : div_r + 1'b1;
        end
    end

    // ========================================================
    // scanners
    // skip masks visits only, scan-end steers the scanner pointer
    tds_scanner #(.N(NUM_DESC)) u_iso_scan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(scan_en_r[CAT_ISO]),
        .step_i(step),
        .skip_i(skip_r[CAT_ISO]),
        .last_i(end_r[CAT_ISO]),
        .visit_o(iso_visit_o),
        .visit_idx_o(iso_visit_idx_o),
        .wrap_o(iso_wrap_o)
    );

    tds_scanner #(.N(NUM_DESC)) u_periodic_scan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(scan_en_r[CAT_PERIODIC]),
        .step_i(step),
        .skip_i(skip_r[CAT_PERIODIC]),
        .last_i(end_r[CAT_PERIODIC]),
        .visit_o(periodic_visit_o),
        .visit_idx_o(periodic_visit_idx_o),
        .wrap_o(periodic_wrap_o)
    );

    tds_scanner #(.N(NUM_DESC)) u_async_scan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(scan_en_r[CAT_ASYNC]),
        .step_i(step),
        .skip_i(skip_r[CAT_ASYNC]),
        .last_i(end_r[CAT_ASYNC]),
        .visit_o(async_visit_o),
        .visit_idx_o(async_visit_idx_o),
        .wrap_o(async_wrap_o)
    );

endmodule
`default_nettype wire

// file: logic/tds_scanner.sv
/*
 sequential scanner over the descriptor positions of one category.
 assumes skip and scan-end maps are stable registers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tds_scanner
    import tds_pkg::*;
#(
    parameter int N = NUM_DESC
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic en_i,
    input wire logic step_i,
    input wire logic [N-1:0] skip_i,
    input wire logic [N-1:0] last_i,
    // descriptor visits
    output logic visit_o,
    output logic [IDX_W-1:0] visit_idx_o,
    output logic wrap_o
);

    // ========================================================
    // position
    logic [IDX_W-1:0] ptr_r;
    logic [IDX_W-1:0] ptr_nxt;
    logic go;
    logic skip_here;
    logic end_here;

    assign go = en_i & step_i;
    assign skip_here = skip_i[ptr_r];
    assign end_here = last_i[ptr_r] | (ptr_r == IDX_W'(N - 1));
    assign ptr_nxt = end_here ? '0 : ptr_r + 1'b1;

    // ========================================================
    // registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ptr_r <= '0;
            visit_o <= 1'b0;
            visit_idx_o <= '0;
            wrap_o <= 1'b0;
        end
        else
        begin
            visit_o <= go & ~skip_here;
            wrap_o <= go & end_here;
            if (!en_i)
            begin
                ptr_r <= '0;
            end
            else if (step_i)
            begin
                visit_idx_o <= ptr_r;
                ptr_r <= ptr_nxt;
            end
        end
    end

endmodule
`default_nettype wire

// file: tb/tb.sv
/*
 self-checking bench for the scan map block.
 drives the wishbone port and completion pulses directly.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
    import tds_pkg::*;
;
    localparam logic [11:0] BASE [3] = '{ISO_COMPLETION_OFS, PERIODIC_COMPLETION_OFS,
                                         ASYNC_COMPLETION_OFS};
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [11:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] dat = 0;
    logic [31:0] dat_o;
    logic ack;
    logic [31:0] dn [3] = '{default: 32'h0};
    logic [2:0] vis;
    logic [2:0] wrp;
    logic [4:0] idx [3];
    logic irq;
    logic [31:0] inj = 0;
    logic [5:0] vq [$];
    int cur = 0;
    int failures = 0;
    int samples_checked = 0;
    always #25 clk_i = ~clk_i;
    tds_scan_maps #(.STEP_DIV(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .iso_done_i(dn[0]), .periodic_done_i(dn[1]),
        .async_done_i(dn[2]), .iso_visit_o(vis[0]), .iso_visit_idx_o(idx[0]),
        .iso_wrap_o(wrp[0]), .periodic_visit_o(vis[1]), .periodic_visit_idx_o(idx[1]),
        .periodic_wrap_o(wrp[1]), .async_visit_o(vis[2]), .async_visit_idx_o(idx[2]),
        .async_wrap_o(wrp[2]), .irq_o(irq));
    always @(posedge clk_i)
        if (vis[cur] === 1'b1)
            vq.push_back({wrp[cur], idx[cur]});
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        if (inj != 0)
            dn[1] <= inj;
        @(posedge clk_i);
        if (inj != 0)
            dn[1] <= 32'h0;
        inj = 0;
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (ack !== 1'b1)
        begin
            failures++;
            report_and_stop();
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        acc(1'b1, a, d, s, q);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, 4'hf, q);
        check("register", q, e);
    endtask
    task automatic pulse(input int c, input logic [31:0] b);
        dn[c] <= b;
        @(posedge clk_i);
        dn[c] <= 32'h0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic scan(input int c, input logic [31:0] sk, input logic [31:0] en, input int nv);
        int p;
        int n;
        wr(BASE[c] + 12'h4, sk, 4'hf);
        wr(BASE[c] + 12'h8, en, 4'hf);
        cur = c;
        vq.delete();
        wr(SCAN_CTRL_OFS, 32'h1 << c, 4'h1);
        p = 0;
        n = 0;
        while (vq.size() < nv && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        if (vq.size() < nv)
        begin
            failures++;
            report_and_stop();
        end
        wr(SCAN_CTRL_OFS, 32'h0, 4'h1);
        for (int k = 0; k < nv; k++)
        begin
            while (sk[p])
                p = (en[p] || p == 31) ? 0 : p + 1;
            check("visit index", {27'h0, vq[k][4:0]}, p);
            check("visit wrap", {31'h0, vq[k][5]}, {31'h0, en[p] || p == 31});
            p = (en[p] || p == 31) ? 0 : p + 1;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 3; i++)
        begin
            rc(BASE[i], 32'h0);
            rc(BASE[i] + 12'h4, 32'hffff_ffff);
            rc(BASE[i] + 12'h8, 32'h0);
        end
        cur = 0;
        vq.delete();
        wr(SCAN_CTRL_OFS, 32'h1, 4'h1);
        repeat (60) @(posedge clk_i);
        wr(SCAN_CTRL_OFS, 32'h0, 4'h1);
        check("visits", vq.size(), 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(BASE[i] + 12'h4, 32'h1234_5678, 4'hf);
            wr(BASE[i] + 12'h4, 32'h0, 4'h3);
            rc(BASE[i] + 12'h4, 32'h1234_0000);
            wr(BASE[i] + 12'h8, 32'h8000_0001, 4'hf);
            rc(BASE[i] + 12'h8, 32'h8000_0001);
            wr(BASE[i], 32'hffff_ffff, 4'hf);
            pulse(i, 32'h8000_0001);
            rc(BASE[i], 32'h8000_0001);
            rc(BASE[i], 32'h0);
        end
        wr(12'h200, 32'hffff_ffff, 4'hf);
        rc(12'h200, 32'h0);
        check("irq", irq, 32'h0);
        wr(IRQ_MASK_OFS, 32'h2, 4'h1);
        check("irq", irq, 32'h1);
        rc(IRQ_STATUS_OFS, 32'h7);
        wr(IRQ_STATUS_OFS, 32'h7, 4'h1);
        check("irq", irq, 32'h0);
        inj = 32'h10;
        rc(PERIODIC_COMPLETION_OFS, 32'h0);
        rc(PERIODIC_COMPLETION_OFS, 32'h10);
        scan(0, 32'h0, 32'h4, 7);
        scan(0, 32'h0, 32'h1, 3);
        scan(0, 32'h0, 32'h2, 5);
        scan(0, 32'h2, 32'h4, 5);
        scan(1, 32'h0, 32'h0, 34);
        scan(2, 32'h5, 32'h8, 5);
        pulse(1, 32'h4);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("irq", irq, 32'h0);
        rc(IRQ_STATUS_OFS, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            rc(BASE[i], 32'h0);
            rc(BASE[i] + 12'h4, 32'hffff_ffff);
            rc(BASE[i] + 12'h8, 32'h0);
        end
        report_and_stop();
    end
endmodule
bind tds_scan_maps tds_scan_maps_monitor #(.STEP_DIV(STEP_DIV)) u_mon (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .periodic_done_i(periodic_done_i), .iso_visit_o(iso_visit_o),
    .iso_visit_idx_o(iso_visit_idx_o), .iso_wrap_o(iso_wrap_o), .irq_o(irq_o));
`default_nettype wire

// file: tb/tds_scan_maps_monitor.sv
/*
 concurrent checks on the scan map block, bound to its top module.
 assumes one clock domain and a master that keeps the bus rules.
*/
`timescale 1ns/1ps
`default_nettype none
module tds_scan_maps_monitor
    import tds_pkg::*;
#(
    parameter int STEP_DIV = SCAN_STEP_DIV
)
(
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // events and scanner
    input wire logic [NUM_DESC-1:0] periodic_done_i,
    input wire logic iso_visit_o,
    input wire logic [IDX_W-1:0] iso_visit_idx_o,
    input wire logic iso_wrap_o,
    input wire logic irq_o
);
    localparam int SPAN = 2 * STEP_DIV;
    // ========================================================
    // shadow registers
    logic [31:0] skip_r;
    logic [31:0] end_r;
    logic [31:0] comp_r;
    logic mask_r;
    wire logic take = wb_cyc_i & wb_stb_i & !wb_ack_o;
    wire logic wr = take & wb_we_i;
    wire logic [9:0] wa = wb_adr_i[11:2];
    wire logic [31:0] bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire logic [31:0] wv = (wb_dat_i & bm);
    wire logic rd_comp = take & !wb_we_i & (wa == PERIODIC_COMPLETION_OFS[11:2]);
    wire logic [31:0] skip_nxt = (wr && wa == ISO_SKIP_OFS[11:2]) ? (skip_r & ~bm) | wv : skip_r;
    wire logic [31:0] end_nxt = (wr && wa == ISO_SCAN_END_OFS[11:2]) ?
        (end_r & ~bm) | wv : end_r;
    wire logic [31:0] comp_nxt = (rd_comp ? 32'h0 : comp_r) | periodic_done_i;
    wire logic mask_nxt = (wr && wa == IRQ_MASK_OFS[11:2] && wb_sel_i[0]) ? wb_dat_i[1] : mask_r;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            skip_r <= SKIP_RST;
            end_r <= SCAN_END_RST;
            comp_r <= COMPLETION_RST;
            mask_r <= 1'b0;
        end
        else
        begin
            skip_r <= skip_nxt;
            end_r <= end_nxt;
            comp_r <= comp_nxt;
            mask_r <= mask_nxt;
        end
    end
    // ========================================================
    // properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_next;
        take |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
    property p_ack_single;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack longer than a cycle");
    property p_unmapped;
        take && !wb_we_i && wb_adr_i == 12'h200 |=> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_comp_read;
        rd_comp |=> wb_dat_o == $past(comp_r);
    endproperty
    a_comp_read: assert property (p_comp_read) else $error("completion read wrong");
    property p_done_irq;
        (|periodic_done_i) && mask_nxt |=> irq_o;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("completion gave no irq");
    property p_skip;
        iso_visit_o |-> !skip_r[iso_visit_idx_o];
    endproperty
    a_skip: assert property (p_skip) else $error("skipped position visited");
    property p_wrap_pos;
        iso_wrap_o |-> end_r[iso_visit_idx_o] || iso_visit_idx_o == 5'h1f;
    endproperty
    a_wrap_pos: assert property (p_wrap_pos) else $error("wrap at wrong position");
    property p_restart;
        iso_wrap_o |-> ##[1:SPAN] iso_visit_idx_o == 5'h00;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart after wrap");
endmodule
`default_nettype wire
